// ==== bench/oag_mem_model.sv ====
// Behavioural data RAM and program memory facing the address generator
module oag_mem_model (
    input  wire logic              mclk,      // Core clock
    input  wire oag_pkg::oag_ram_t ram,       // Data RAM access
    input  wire oag_pkg::oag_pm_t  pm,        // Program memory access
    output logic [15:0]            ram_rdata, // Data RAM read word
    output logic [15:0]            pm_rdata   // Program memory read word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [512];

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 16'h3C00 + 16'(i);
        end
    end

    // Read data stands while the strobe does; otherwise the inverse, so stale words never pass
    assign ram_rdata = ram.rd ? mem[ram.addr] : ~mem[ram.addr];
    assign pm_rdata  = pm.rd ? (pm.addr ^ 16'h5A5A) : ~(pm.addr ^ 16'h5A5A);

    always @(posedge mclk) begin
        if (ram.wr) mem[ram.addr] <= ram.wdata;
    end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench of the operand address generator
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk = 1'b0;
    logic              rstn = 1'b0;
    oag_pkg::oag_req_t req = '0;
    logic [15:0]       acc = 16'h0000;
    logic [1:0]        status_word_dp = 2'h0;
    logic [1:0]        loop_bits = 2'h0;
    logic [15:0]       ram_rdata, pm_rdata, wr_d, pm_a, lat;
    logic [8:0]        rd_a, wr_a;
    oag_pkg::oag_ram_t ram;
    oag_pkg::oag_pm_t  pm;
    oag_pkg::oag_rsp_t rsp, got;
    logic              busy;
    int                fail_count = 0;
    int                n_compared = 0;
    int                cycles = 0;

    always #25 mclk = ~mclk;

    oag_core u_dut (.mclk(mclk), .rstn(rstn), .req(req), .acc(acc),
        .status_word_dp(status_word_dp), .loop_bits(loop_bits), .ram_rdata(ram_rdata),
        .pm_rdata(pm_rdata), .ram(ram), .pm(pm), .rsp(rsp), .busy(busy));
    oag_mem_model u_mem (.mclk(mclk), .ram(ram), .pm(pm), .ram_rdata(ram_rdata),
        .pm_rdata(pm_rdata));

    // Last access of each kind, for the scenario checks
    always @(posedge mclk) begin
        if (ram.rd) rd_a <= ram.addr;
        if (ram.wr) wr_a <= ram.addr;
        if (ram.wr) wr_d <= ram.wdata;
        if (pm.rd) pm_a <= pm.addr;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            results();
        end
    end

    task automatic results();
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic oag_pkg::oag_req_t mk(oag_pkg::oag_mode_t m, logic [2:0] d,
        logic [2:0] s, logic b, oag_pkg::oag_upd_t u, logic [8:0] a, logic [15:0] i);
        oag_pkg::oag_req_t r;
        r = '0;
        r.mode = m;
        r.dst_sel = d;
        r.src_sel = s;
        r.bank = b;
        r.upd = u;
        r.direct = a;
        r.imm = i;
        return r;
    endfunction

    // One request; lat holds the cycles to the answer, got the answer itself
    task automatic issue(input oag_pkg::oag_req_t r);
        int n;
        r.valid = 1'b1;
        @(posedge mclk);
        #1 req = r;
        @(posedge mclk);
        #1 req.valid = 1'b0;
        lat = 16'h0000;
        // A one-cycle answer already stands after the edge that took the request
        for (n = 1; n <= 8 && lat == 16'h0000; n++) begin
            if (rsp.valid === 1'b1) begin
                lat = 16'(n);
                got = rsp;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
        for (n = 0; n < 8 && (n == 0 || busy !== 1'b0); n++) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic t_direct();
        logic [8:0] a [4] = '{9'd0, 9'd255, 9'd256, 9'd511};
        for (int k = 0; k < 4; k++) begin
            issue(mk(oag_pkg::OAG_M_DIRECT, 3'd6, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, a[k], 0));
            chk(16'(rd_a), 16'(a[k]));
            chk(got.data, 16'h3C00 + 16'(a[k]));
            chk(lat, 16'h0002);
        end
        acc = 16'hA55A;
        issue(mk(oag_pkg::OAG_M_DIRECT, 3'd0, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, 9'd300, 0));
        chk(16'(wr_a), 16'h012C);
        chk(wr_d, 16'hA55A);
        chk(lat, 16'h0001);
    endtask

    task automatic t_imm_regind();
        oag_pkg::oag_upd_t u [6] = '{oag_pkg::OAG_U_INC, oag_pkg::OAG_U_PLAIN,
            oag_pkg::OAG_U_LOOP_DEC, oag_pkg::OAG_U_LOOP_DEC, oag_pkg::OAG_U_LOOP_INC,
            oag_pkg::OAG_U_PLAIN};
        logic [8:0] e [6] = '{9'h140, 9'h141, 9'h141, 9'h140, 9'h143, 9'h140};
        issue(mk(oag_pkg::OAG_M_LIMM, 3'd3, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 16'hBEEF));
        chk(got.data, 16'hBEEF);
        chk(16'({got.reg_wr, got.reg_dst}), 16'h000B);
        issue(mk(oag_pkg::OAG_M_SIMM, 3'd1, 3'd0, 1'b1, oag_pkg::OAG_U_PLAIN, 0, 16'h0040));
        chk(lat, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            issue(mk(oag_pkg::OAG_M_REGIND, 3'd0, 3'd1, 1'b1, u[k], 0, 0));
            chk(16'(rd_a), 16'(e[k]));
            chk(got.data, 16'h3C00 + 16'(e[k]));
        end
        loop_bits = 2'h3;
        issue(mk(oag_pkg::OAG_M_SIMM, 3'd1, 3'd0, 1'b1, oag_pkg::OAG_U_PLAIN, 0, 16'h0047));
        issue(mk(oag_pkg::OAG_M_REGIND, 3'd0, 3'd1, 1'b1, oag_pkg::OAG_U_LOOP_INC, 0, 0));
        chk(16'(rd_a), 16'h0147);
        issue(mk(oag_pkg::OAG_M_REGIND, 3'd0, 3'd1, 1'b1, oag_pkg::OAG_U_PLAIN, 0, 0));
        chk(16'(rd_a), 16'h0140);
        loop_bits = 2'h0;
    endtask

    task automatic t_program();
        acc = 16'h1234;
        issue(mk(oag_pkg::OAG_M_ACCIND, 3'd6, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 0));
        chk(pm_a, 16'h1234);
        chk(got.data, 16'h1234 ^ 16'h5A5A);
        chk(lat, 16'h0002);
        issue(mk(oag_pkg::OAG_M_SIMM, 3'd2, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 16'h0010));
        for (int k = 0; k < 2; k++) begin
            issue(mk(oag_pkg::OAG_M_MEMIND_P, 3'd6, 3'd2, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 0));
            chk(16'(rd_a), 16'h0010);
            chk(pm_a, 16'h3C10 + 16'(k));
            chk(got.data, (16'h3C10 + 16'(k)) ^ 16'h5A5A);
            chk(wr_d, 16'h3C11 + 16'(k));
            chk(lat, 16'h0003);
        end
        status_word_dp = 2'b10;
        issue(mk(oag_pkg::OAG_M_MEMIND_D, 3'd6, 3'd1, 1'b1, oag_pkg::OAG_U_PLAIN, 0, 0));
        chk(16'(rd_a), 16'h0109);
        chk(pm_a, 16'h3D09);
        chk(wr_d, 16'h3D0A);
        issue(mk(oag_pkg::OAG_M_DREGS, 3'd6, 3'd1, 1'b1, oag_pkg::OAG_U_PLAIN, 0, 0));
        chk(16'(rd_a), 16'h0109);
        chk(got.data, 16'h3D0A);
    endtask

    task automatic t_regs();
        oag_pkg::oag_req_t r;
        issue(mk(oag_pkg::OAG_M_PREGS, 3'd5, 3'd2, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 0));
        chk(16'({got.reg_wr, got.reg_dst}), 16'h000D);
        chk(got.data, 16'h0010);
        for (int k = 0; k < 8; k++) begin
            issue(mk(oag_pkg::OAG_M_HWREGS, 3'(k), 3'(7 - k), 1'b0, oag_pkg::OAG_U_PLAIN, 0, 0));
            chk(16'({got.hw_valid, got.hw_dst, got.hw_src}), 16'(64 + k * 8 + 7 - k));
        end
        // Switch is on only when the operand is present and says on
        for (int k = 0; k < 3; k++) begin
            got = '0;
            r = mk(oag_pkg::OAG_M_PREGS, 3'd0, 3'd0, 1'b0, oag_pkg::OAG_U_PLAIN, 0, 0);
            r.bank_sw_en = (k != 2);
            r.bank_sw_on = (k != 1);
            issue(r);
            chk(16'(got.bank_sw), 16'(k == 0));
        end
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        #1 rstn = 1'b1;
        chk(16'({rsp.valid, ram.rd, ram.wr, pm.rd, busy}), 16'h0000);
        t_direct();
        t_imm_regind();
        t_program();
        t_regs();
        results();
    end
endmodule

// ==== design/oag_core.sv ====
// Operand addressing-mode decoder and address generator
module oag_core (
    input  wire logic              mclk,      // 20 MHz core clock
    input  wire logic              rstn,      // Synchronous reset, active low
    input  wire oag_pkg::oag_req_t req,       // Decoded operand request
    input  wire logic [15:0]       acc,       // Accumulator contents
    input  wire logic [1:0]        status_word_dp, // Status bits selecting data page
    input  wire logic [1:0]        loop_bits, // Loop window size
    input  wire logic [15:0]       ram_rdata, // Data RAM read word
    input  wire logic [15:0]       pm_rdata,  // Program memory read word
    output oag_pkg::oag_ram_t      ram,       // Data RAM access
    output oag_pkg::oag_pm_t       pm,        // Program memory access
    output oag_pkg::oag_rsp_t      rsp,       // Operand answer
    output logic                   busy       // Multi-cycle access under way
);
    typedef enum logic [2:0] {
        OAG_S_IDLE, OAG_S_RAM, OAG_S_PMEM, OAG_S_PRD, OAG_S_WB
    } oag_state_t;

    typedef struct packed {
        oag_state_t          st;
        logic [7:0][7:0]     ptr;
        logic [2:0]          cur_ptr;
        logic                use_ptr;
        logic [8:0]          ind_addr;
        logic [15:0]         pm_addr;
        logic [2:0]          dst;
        oag_pkg::oag_upd_t   upd;
        oag_pkg::oag_ram_t   ram;
        oag_pkg::oag_pm_t    pm;
        oag_pkg::oag_rsp_t   rsp;
        logic                busy;
    } oag_core_state_t;

    oag_core_state_t st_ff;
    oag_core_state_t nxt_st;
    logic [7:0]      upd_ptr;
    logic [2:0]      psel;

    assign psel = {req.bank, req.src_sel[1:0]};

    oag_ptr_update u_upd (
        .ptr       (st_ff.ptr[st_ff.cur_ptr]),
        .upd       (st_ff.upd),
        .loop_bits (loop_bits),
        .nxt_ptr   (upd_ptr)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ram.rd = 1'b0;
        nxt_st.ram.wr = 1'b0;
        nxt_st.pm.rd = 1'b0;
        nxt_st.rsp.valid = 1'b0;
        nxt_st.rsp.reg_wr = 1'b0;
        nxt_st.rsp.hw_valid = 1'b0;
        unique case (st_ff.st)
            OAG_S_IDLE: begin
                nxt_st.busy = 1'b0;
                if (req.valid) begin
                    nxt_st.dst = req.dst_sel;
                    nxt_st.rsp.reg_dst = req.dst_sel;
                    nxt_st.rsp.bank_sw = req.bank_sw_en & req.bank_sw_on;
                    nxt_st.upd = req.upd;
                    nxt_st.use_ptr = 1'b0;
                    nxt_st.cur_ptr = psel;
                    unique case (req.mode)
                        oag_pkg::OAG_M_PREGS: begin
                            nxt_st.rsp.data = {8'h00, st_ff.ptr[psel]};
                            nxt_st.rsp.reg_wr = 1'b1;
                            nxt_st.rsp.valid = 1'b1;
                        end
                        oag_pkg::OAG_M_HWREGS: begin
                            nxt_st.rsp.hw_dst = oag_pkg::oag_hw_t'(req.dst_sel);
                            nxt_st.rsp.hw_src = oag_pkg::oag_hw_t'(req.src_sel);
                            nxt_st.rsp.hw_valid = 1'b1;
                            nxt_st.rsp.valid = 1'b1;
                        end
                        oag_pkg::OAG_M_DREGS: begin
                            nxt_st.ram.addr = {req.bank, 4'h0,
                                               status_word_dp, req.src_sel[1:0]};
                            nxt_st.ram.rd = 1'b1;
                            nxt_st.st = OAG_S_RAM;
                            nxt_st.busy = 1'b1;
                        end
                        oag_pkg::OAG_M_ACCIND: begin
                            nxt_st.pm.addr = acc;
                            nxt_st.pm.rd = 1'b1;
                            nxt_st.st = OAG_S_PRD;
                            nxt_st.busy = 1'b1;
                        end
                        oag_pkg::OAG_M_DIRECT: begin
                            // Bit 8 of the absolute address is the bank
                            nxt_st.ram.addr = req.direct;
                            nxt_st.ram.wr = req.dst_sel == 3'(oag_pkg::OAG_H_ACC) ? 1'b0 : 1'b1;
                            nxt_st.ram.rd = ~nxt_st.ram.wr;
                            nxt_st.ram.wdata = acc;
                            nxt_st.st = nxt_st.ram.rd ? OAG_S_RAM : OAG_S_IDLE;
                            nxt_st.rsp.valid = nxt_st.ram.wr;
                            nxt_st.busy = nxt_st.ram.rd;
                        end
                        oag_pkg::OAG_M_LIMM: begin
                            nxt_st.rsp.data = req.imm;
                            nxt_st.rsp.reg_wr = 1'b1;
                            nxt_st.rsp.valid = 1'b1;
                        end
                        oag_pkg::OAG_M_SIMM: begin
                            nxt_st.rsp.data = {8'h00, req.imm[7:0]};
                            nxt_st.ptr[{req.bank, req.dst_sel[1:0]}] = req.imm[7:0];
                            nxt_st.rsp.valid = 1'b1;
                        end
                        oag_pkg::OAG_M_REGIND: begin
                            nxt_st.ram.addr = {req.bank, st_ff.ptr[psel]};
                            nxt_st.ram.rd = 1'b1;
                            nxt_st.use_ptr = 1'b1;
                            nxt_st.st = OAG_S_RAM;
                            nxt_st.busy = 1'b1;
                        end
                        oag_pkg::OAG_M_MEMIND_P: begin
                            nxt_st.ind_addr = {req.bank, st_ff.ptr[psel]};
                            nxt_st.ram.addr = {req.bank, st_ff.ptr[psel]};
                            nxt_st.ram.rd = 1'b1;
                            nxt_st.use_ptr = 1'b1;
                            nxt_st.st = OAG_S_PMEM;
                            nxt_st.busy = 1'b1;
                        end
                        oag_pkg::OAG_M_MEMIND_D: begin
                            // Data register picks the RAM word, single indirection only
                            nxt_st.ind_addr = {req.bank, 4'h0, status_word_dp,
                                               req.src_sel[1:0]};
                            nxt_st.ram.addr = nxt_st.ind_addr;
                            nxt_st.ram.rd = 1'b1;
                            nxt_st.upd = oag_pkg::OAG_U_PLAIN;
                            nxt_st.st = OAG_S_PMEM;
                            nxt_st.busy = 1'b1;
                        end
                        default: nxt_st.busy = 1'b0;
                    endcase
                end
            end
            OAG_S_RAM: begin
                nxt_st.rsp.data = ram_rdata;
                nxt_st.rsp.reg_wr = 1'b1;
                nxt_st.rsp.valid = 1'b1;
                nxt_st.st = st_ff.use_ptr ? OAG_S_WB : OAG_S_IDLE;
                nxt_st.busy = st_ff.use_ptr;
            end
            OAG_S_PMEM: begin
                nxt_st.pm.addr = ram_rdata;
                nxt_st.pm.rd = 1'b1;
                nxt_st.ram.addr = st_ff.ind_addr;
                nxt_st.ram.wdata = ram_rdata + 16'h0001;
                nxt_st.ram.wr = 1'b1;
                nxt_st.st = OAG_S_PRD;
            end
            OAG_S_PRD: begin
                nxt_st.rsp.data = pm_rdata;
                nxt_st.rsp.reg_wr = 1'b1;
                nxt_st.rsp.valid = 1'b1;
                nxt_st.st = st_ff.use_ptr ? OAG_S_WB : OAG_S_IDLE;
                nxt_st.busy = st_ff.use_ptr;
            end
            OAG_S_WB: begin
                // Write-back after the access so the next operand sees it
                nxt_st.ptr[st_ff.cur_ptr] = upd_ptr;
                nxt_st.st = OAG_S_IDLE;
                nxt_st.busy = 1'b0;
            end
            default: nxt_st.st = OAG_S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.st <= OAG_S_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ram  = st_ff.ram;
    assign pm   = st_ff.pm;
    assign rsp  = st_ff.rsp;
    assign busy = st_ff.busy;

    sequence s_pm_fetch;
        st_ff.st == OAG_S_PMEM;
    endsequence

    a_limm_word: assert property (@(posedge mclk) disable iff (!rstn)
        req.valid && st_ff.st == OAG_S_IDLE && req.mode == oag_pkg::OAG_M_LIMM
        |=> rsp.valid && rsp.data == $past(req.imm))
        else $error("long immediate not passed");
    a_accind_addr: assert property (@(posedge mclk) disable iff (!rstn)
        req.valid && st_ff.st == OAG_S_IDLE && req.mode == oag_pkg::OAG_M_ACCIND
        |=> pm.rd && pm.addr == $past(acc))
        else $error("accumulator indirect address wrong");
    a_direct_bank: assert property (@(posedge mclk) disable iff (!rstn)
        req.valid && st_ff.st == OAG_S_IDLE && req.mode == oag_pkg::OAG_M_DIRECT
        |=> ram.addr[8] == ($past(req.direct) > 9'(oag_pkg::BANK0_LAST)))
        else $error("direct bank select wrong");
    a_dreg_range: assert property (@(posedge mclk) disable iff (!rstn)
        req.valid && st_ff.st == OAG_S_IDLE && req.mode == oag_pkg::OAG_M_DREGS
        |=> ram.addr[7:4] == 4'h0 && ram.addr[3:2] == $past(status_word_dp))
        else $error("data register address out of range");
    a_mem_incr: assert property (@(posedge mclk) disable iff (!rstn)
        s_pm_fetch |=> ram.wr && ram.wdata == $past(ram_rdata) + 16'h0001)
        else $error("stored program address not incremented");
    a_double_ind: assert property (@(posedge mclk) disable iff (!rstn)
        s_pm_fetch |=> pm.rd && pm.addr == $past(ram_rdata))
        else $error("double indirect address wrong");
    a_regind_addr: assert property (@(posedge mclk) disable iff (!rstn)
        req.valid && st_ff.st == OAG_S_IDLE && req.mode == oag_pkg::OAG_M_REGIND
        |=> ram.rd && ram.addr == {$past(req.bank), $past(st_ff.ptr[psel])})
        else $error("pointer indirect address wrong");
    a_ptr_wback: assert property (@(posedge mclk) disable iff (!rstn)
        st_ff.st == OAG_S_WB |=> st_ff.ptr[$past(st_ff.cur_ptr)] == $past(upd_ptr))
        else $error("pointer not written back");
endmodule

// ==== design/oag_ptr_update.sv ====
// Next pointer value for the four indirect update variants
module oag_ptr_update (
    input  wire logic [7:0]       ptr,      // Current pointer
    input  wire oag_pkg::oag_upd_t upd,     // Update variant
    input  wire logic [1:0]       loop_bits,// Loop size, 2**n locations, at least 4
    output logic [7:0]            nxt_ptr   // Updated pointer
);
    logic [7:0] mask;
    logic [7:0] step;

    always_comb begin
        mask = 8'(({8'h00, 8'h01} << loop_bits) - 8'h01) | 8'h03;
        unique case (upd)
            oag_pkg::OAG_U_PLAIN:    step = ptr;
            oag_pkg::OAG_U_INC:      step = ptr + 8'h01;
            // Loop variants wrap inside a window so buffers cycle without a test
            oag_pkg::OAG_U_LOOP_DEC: step = (ptr & ~mask) | ((ptr - 8'h01) & mask);
            oag_pkg::OAG_U_LOOP_INC: step = (ptr & ~mask) | ((ptr + 8'h01) & mask);
        endcase
        nxt_ptr = step;
    end
endmodule

// ==== include/oag_pkg.sv ====
// Shared types and constants of the operand address generator
package oag_pkg;

    localparam int DW            = 16;
    localparam int RAW           = 9;   // Bank bit plus 8-bit location
    localparam int BANK0_LAST    = 255;
    localparam int BANK1_FIRST   = 256;
    localparam int DIRECT_LAST   = 511;
    localparam int DREG_LOCS     = 16;
    localparam int SIMM_W        = 8;
    localparam int NPTR          = 8;   // Pointer registers, four per bank
    localparam int PTR_SEL_W     = 3;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  RST_PTR   = 8'h00;
    localparam logic [1:0]  RST_LOOPB = 2'h0;

    // Addressing mode of an operand
    typedef enum logic [3:0] {
        OAG_M_PREGS, OAG_M_HWREGS, OAG_M_DREGS, OAG_M_ACCIND, OAG_M_DIRECT,
        OAG_M_LIMM, OAG_M_SIMM, OAG_M_REGIND, OAG_M_MEMIND_P, OAG_M_MEMIND_D
    } oag_mode_t;

    // Pointer update after an indirect access
    typedef enum logic [1:0] {
        OAG_U_PLAIN, OAG_U_INC, OAG_U_LOOP_DEC, OAG_U_LOOP_INC
    } oag_upd_t;

    // Hardware register targets
    typedef enum logic [2:0] {
        OAG_H_X, OAG_H_Y, OAG_H_PC, OAG_H_STATUS, OAG_H_PROD, OAG_H_EXT,
        OAG_H_ACC, OAG_H_BUS
    } oag_hw_t;

    // Decoded operand request
    typedef struct packed {
        logic       valid;
        oag_mode_t  mode;
        logic [2:0] dst_sel;   // Destination register, first in field
        logic [2:0] src_sel;   // Source register, second in field
        logic       bank;
        oag_upd_t   upd;
        logic [8:0] direct;
        logic [15:0] imm;
        logic       bank_sw_en;
        logic       bank_sw_on;
    } oag_req_t;

    // Data memory access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [8:0]  addr;
        logic [15:0] wdata;
    } oag_ram_t;

    // Program memory access
    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } oag_pm_t;

    // Operand answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic        reg_wr;
        logic [2:0]  reg_dst;
        logic        hw_valid;
        oag_hw_t     hw_dst;
        oag_hw_t     hw_src;
        logic        bank_sw;
    } oag_rsp_t;

endpackage
